// file: hw/swdbg_pkg.sv
// shared constants for the single-wire debug bit port
package swdbg_pkg;
    // bit timing in debug clock cycles
    localparam int unsigned BIT_CYCLES = 16;
    localparam logic [9:0] SAMPLE_AT = 10'h00a;
    localparam logic [9:0] ONE_PULSE_AT = 10'h007;
    localparam logic [9:0] ZERO_LOW_END = 10'h00d;
    localparam logic [9:0] TIMEOUT_CYCLES = 10'h200;
    localparam logic [9:0] BIT_END = 10'h010;
    // cycles after reset release until the synchroniser holds the pad level
    localparam logic [1:0] STRAP_AT = 2'h2;
    // command framing
    localparam int unsigned CMD_BITS = 8;
    localparam logic [7:0] CMD_RESET = 8'h00;
    // command codes handled by this port
    localparam logic [7:0] CMD_BACKGROUND = 8'h90;
    localparam logic [7:0] CMD_GO = 8'h08;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_TAGGO = 8'h18;
    localparam logic [7:0] CMD_WRCTRL = 8'hc4;
    localparam logic [7:0] CMD_RDSTAT = 8'he4;
    // control byte field positions
    localparam int unsigned CLKSEL_BIT = 3;
    localparam int unsigned ENABLE_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // bit engine states, one-hot
    typedef enum logic [2:0] {
        SWDBG_IDLE = 3'b001,
        SWDBG_RX = 3'b010,
        SWDBG_TX = 3'b100
    } swdbg_bit_t;
endpackage

// file: hw/swdbg_sync.sv
// two-stage synchroniser with falling edge detect
`timescale 1ns/1ps
module swdbg_sync
    import swdbg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic asyncIn,
    output logic syncOut,
    output logic fallPulse
);
    logic stage1_ff; // first stage, read only by stage two
    logic stage2_ff; // safe level
    logic prev_ff; // level one cycle older
    logic [1:0] fill_ff; // cycles since reset, stops once stages hold pad level

    // two flops then edge detect on the safe copy
    // synchronise before use
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1_ff <= 1'b1;
            stage2_ff <= 1'b1;
            prev_ff <= 1'b1;
            fill_ff <= 2'h0;
        end
        else
        begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
            prev_ff <= stage2_ff;
            // count until the stale reset levels have left the stages
            if (fill_ff <= STRAP_AT)
                fill_ff <= fill_ff + 2'h1;
        end
    end

    assign syncOut = stage2_ff;
    // async edge recognised
    // masked while a wire held low through reset reaches stage two
    assign fallPulse = prev_ff & ~stage2_ff & (fill_ff > STRAP_AT);
endmodule

// file: hw/swdbg_port.sv
// single-wire debug bit port, target side
`timescale 1ns/1ps
module swdbg_port
    import swdbg_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic porFlag,
    input wire logic forceBgReq,
    input wire logic cpuStopped,
    input wire logic [ADDR_W-1:0] cpuAddr,
    input wire logic [ADDR_W-1:0] bkptAddr,
    input wire logic debugWireIn,
    output logic debugWireOut,
    output logic debugWireOe_n,
    output logic activeBackground,
    output logic debugClockSelect,
    output logic cpuResume,
    output logic cpuStep,
    output logic cpuWake,
    output logic oscKeepRun,
    output logic watchdogHold,
    output logic bkptHit,
    output logic cmdAbort
);
    ////////////////////////////////////////////////////////////////
    // wire synchroniser
    logic wireSync; // synchronised wire level
    logic wireFall; // host falling edge, one cycle pulse

    swdbg_sync uSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(debugWireIn),
        .syncOut(wireSync),
        .fallPulse(wireFall)
    );

    ////////////////////////////////////////////////////////////////
    // state
    swdbg_bit_t bitState_ff; // bit engine state
    logic [9:0] bitCnt_ff; // cycles since perceived bit start
    logic [9:0] idleCnt_ff; // cycles since last host edge
    logic [7:0] shift_ff; // received bits, msb first
    logic [3:0] rxCount_ff; // bits received in this byte
    logic [7:0] cmd_ff; // latched command code
    logic cmdValid_ff; // write-control code held, data byte expected
    logic [7:0] txData_ff; // byte being returned
    logic [3:0] txLeft_ff; // bits still to return
    logic txBit_ff; // bit value of current tx slot
    logic [7:0] ctrl_ff; // control byte
    logic bg_ff; // active background flag
    logic forceArm_ff; // forced-background bit seen
    logic [1:0] strapDly_ff; // cycles since reset, strap taken at STRAP_AT
    logic wireOut_ff; // pad drive value
    logic wireOe_n_ff; // pad enable, low drives
    logic resume_ff;
    logic step_ff;
    logic wake_ff;
    logic bkpt_ff;
    logic abort_ff;

    // timeout after too many cycles without a host edge
    logic timeout;
    assign timeout = (idleCnt_ff == TIMEOUT_CYCLES - 10'h001);

    // checks the cpu group that needs background mode
    function automatic logic needsBg(input logic [7:0] code);
        needsBg = (code == CMD_GO) || (code == CMD_STEP) || (code == CMD_TAGGO)
            || (code[7:6] == 2'b01);
    endfunction

    ////////////////////////////////////////////////////////////////
    // idle counter between host edges
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            idleCnt_ff <= 10'h000;
        else if (wireFall || timeout)
            idleCnt_ff <= 10'h000;
        else
            idleCnt_ff <= idleCnt_ff + 10'h001;
    end

    ////////////////////////////////////////////////////////////////
    // bit engine: receive or transmit one bit per host edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bitState_ff <= SWDBG_IDLE;
            bitCnt_ff <= 10'h000;
        end
        else
        begin
            case (bitState_ff)
                SWDBG_IDLE:
                begin
                    if (wireFall)
                    begin
                        bitState_ff <= (txLeft_ff != 4'h0) ? SWDBG_TX : SWDBG_RX;
                        bitCnt_ff <= 10'h001;
                    end
                end
                SWDBG_RX, SWDBG_TX:
                begin
                    if (bitCnt_ff == BIT_END - 10'h001 || timeout)
                    begin
                        bitState_ff <= SWDBG_IDLE;
                        bitCnt_ff <= 10'h000;
                    end
                    else
                    begin
                        bitCnt_ff <= bitCnt_ff + 10'h001;
                    end
                end
                default:
                    bitState_ff <= SWDBG_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // pad driver, only in transmit slots
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wireOut_ff <= 1'b1;
            wireOe_n_ff <= 1'b1;
        end
        else if (bitState_ff != SWDBG_TX)
        begin
            wireOut_ff <= 1'b1;
            wireOe_n_ff <= 1'b1;
        end
        else if (txBit_ff)
        begin
            wireOut_ff <= 1'b1;
            wireOe_n_ff <= ~(bitCnt_ff == ONE_PULSE_AT - 10'h001);
        end
        else
        begin
            wireOut_ff <= (bitCnt_ff == ZERO_LOW_END + 10'h001);
            wireOe_n_ff <= ~(bitCnt_ff <= ZERO_LOW_END + 10'h001);
        end
    end

    ////////////////////////////////////////////////////////////////
    // receive shifter and command decode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_ff <= 8'h00;
            rxCount_ff <= 4'h0;
            cmd_ff <= CMD_RESET;
            cmdValid_ff <= 1'b0;
            txData_ff <= 8'h00;
            txLeft_ff <= 4'h0;
            txBit_ff <= 1'b0;
            ctrl_ff <= CTRL_RESET;
            resume_ff <= 1'b0;
            step_ff <= 1'b0;
            wake_ff <= 1'b0;
        end
        else
        begin
            resume_ff <= 1'b0;
            step_ff <= 1'b0;
            wake_ff <= 1'b0;
            if (timeout)
            begin
                rxCount_ff <= 4'h0;
                cmdValid_ff <= 1'b0;
                txLeft_ff <= 4'h0;
            end
            else if (bitState_ff == SWDBG_RX && bitCnt_ff == SAMPLE_AT)
            begin
                if (rxCount_ff == 4'(CMD_BITS - 1))
                begin
                    rxCount_ff <= 4'h0;
                    if (cmdValid_ff)
                    begin
                        // data byte of write-control
                        cmdValid_ff <= 1'b0;
                        ctrl_ff <= {shift_ff[6:0], wireSync};
                    end
                    else
                    begin
                        cmd_ff <= {shift_ff[6:0], wireSync};
                        cmdValid_ff <= ({shift_ff[6:0], wireSync} == CMD_WRCTRL);
                        if ({shift_ff[6:0], wireSync} == CMD_RDSTAT)
                        begin
                            txData_ff <= {ctrl_ff[7:1], bg_ff};
                            txLeft_ff <= 4'(CMD_BITS);
                        end
                        if ({shift_ff[6:0], wireSync} == CMD_BACKGROUND)
                        begin
                            wake_ff <= cpuStopped && ctrl_ff[ENABLE_BIT];
                        end
                        if (bg_ff && needsBg({shift_ff[6:0], wireSync}))
                        begin
                            resume_ff <= ({shift_ff[6:0], wireSync} == CMD_GO)
                                || ({shift_ff[6:0], wireSync} == CMD_TAGGO);
                            step_ff <= ({shift_ff[6:0], wireSync} == CMD_STEP);
                        end
                    end
                end
                else
                begin
                    rxCount_ff <= rxCount_ff + 4'h1;
                end
                shift_ff <= {shift_ff[6:0], wireSync};
            end
            else if (bitState_ff == SWDBG_IDLE && wireFall && txLeft_ff != 4'h0)
            begin
                txBit_ff <= txData_ff[7];
                txData_ff <= {txData_ff[6:0], 1'b0};
                txLeft_ff <= txLeft_ff - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode selection at reset release and by command
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bg_ff <= 1'b0;
            strapDly_ff <= 2'h0;
            forceArm_ff <= 1'b0;
        end
        else
        begin
            // wait until stage two holds the pad level of the release
            if (strapDly_ff <= STRAP_AT)
                strapDly_ff <= strapDly_ff + 2'h1;
            if (strapDly_ff == STRAP_AT)
                bg_ff <= porFlag && !wireSync;
            else if (forceArm_ff && wireFall)
            begin
                bg_ff <= 1'b1;
                forceArm_ff <= 1'b0;
            end
            else if (wake_ff)
                bg_ff <= 1'b1;
            else if (resume_ff)
                bg_ff <= 1'b0;
            // a new request wins over the clear of the old one
            if (forceBgReq)
                forceArm_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // side effects: breakpoint, watchdog, oscillator, abort flag
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bkpt_ff <= 1'b0;
            abort_ff <= 1'b0;
        end
        else
        begin
            bkpt_ff <= ctrl_ff[ENABLE_BIT] && (cpuAddr == bkptAddr);
            abort_ff <= timeout && (bitState_ff != SWDBG_IDLE || rxCount_ff != 4'h0
                || txLeft_ff != 4'h0 || cmdValid_ff);
        end
    end

    assign watchdogHold = bg_ff;
    assign oscKeepRun = ctrl_ff[ENABLE_BIT];
    assign debugClockSelect = ctrl_ff[CLKSEL_BIT];
    assign activeBackground = bg_ff;
    assign debugWireOut = wireOut_ff;
    assign debugWireOe_n = wireOe_n_ff;
    assign cpuResume = resume_ff;
    assign cpuStep = step_ff;
    assign cpuWake = wake_ff;
    assign bkptHit = bkpt_ff;
    assign cmdAbort = abort_ff;
endmodule

// file: tb/swdbg_host.sv
// host pod model driving the pseudo-open-drain debug wire
`timescale 1ns/1ps
module swdbg_host
(
    input wire logic clk,
    input wire logic debugWireOut,
    input wire logic debugWireOe_n,
    output logic padLevel
);
    logic hostDrv = 1'b0; // pod drives the wire
    logic hostLvl = 1'b1; // level the pod drives
    ////////////////////////////////////////////////////////////////////////////////
    // wire level, pullup when nobody drives
    assign padLevel = !debugWireOe_n ? debugWireOut : (hostDrv ? hostLvl : 1'b1);
    // host opens bit, drives both levels
    task automatic send_bit(input logic b);
        hostDrv <= 1'b1;
        hostLvl <= 1'b0;
        repeat (4) @(posedge clk);
        hostLvl <= b;
        repeat (10) @(posedge clk);
        hostLvl <= 1'b1;
        @(posedge clk);
        hostDrv <= 1'b0;
        repeat (9) @(posedge clk);
    endtask
    // low until target drives, release before seven, sample at ten
    task automatic recv_bit(output logic b);
        hostDrv <= 1'b1;
        hostLvl <= 1'b0;
        repeat (5) @(posedge clk);
        hostDrv <= 1'b0;
        repeat (5) @(posedge clk);
        b = padLevel;
        repeat (14) @(posedge clk);
    endtask
    task automatic send_byte(input logic [7:0] v);
        @(posedge clk);
        for (int i = 7; i >= 0; i--)
            send_bit(v[i]);
    endtask
    task automatic recv_byte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            recv_bit(v[i]);
    endtask
endmodule

// file: tb/swdbg_port_sva.sv
// assertion checker for the debug bit port
`timescale 1ns/1ps
module swdbg_port_sva
    import swdbg_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic porFlag,
    input wire logic [ADDR_W-1:0] cpuAddr,
    input wire logic [ADDR_W-1:0] bkptAddr,
    input wire logic debugWireIn,
    input wire logic debugWireOut,
    input wire logic debugWireOe_n,
    input wire logic activeBackground,
    input wire logic oscKeepRun,
    input wire logic watchdogHold,
    input wire logic cpuResume,
    input wire logic cpuStep,
    input wire logic cpuWake,
    input wire logic bkptHit,
    input wire logic cmdAbort
);
    logic wirePrev_ff; // last wire level
    logic [9:0] quiet_ff; // cycles since host fall
    ////////////////////////////////////////////////////////////////////////////////
    // time since the last fall on the wire
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wirePrev_ff <= 1'b1;
            quiet_ff <= 10'h000;
        end
        else
        begin
            wirePrev_ff <= debugWireIn;
            if (wirePrev_ff && !debugWireIn)
                quiet_ff <= 10'h000;
            else if (quiet_ff != 10'h3ff)
                quiet_ff <= quiet_ff + 10'h001;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    bg_entry_a: assert property (
        $fell(sys_rst) |-> ##3 activeBackground == ($past(porFlag) && !$past(debugWireIn, 3)))
        else $error("wrong mode after reset");
    watchdog_hold_a: assert property (
        watchdogHold == activeBackground) else $error("watchdog hold wrong");
    bkpt_match_a: assert property (
        1'b1 |=> bkptHit == $past(oscKeepRun && cpuAddr == bkptAddr))
        else $error("breakpoint wrong");
    speedup_short_a: assert property (
        !debugWireOe_n && debugWireOut |=> debugWireOe_n) else $error("long speedup");
    zero_low_a: assert property (
        $fell(debugWireOe_n) && !debugWireOut |-> (!debugWireOe_n && !debugWireOut)[*8]
        ##1 (!debugWireOe_n && !debugWireOut)[*5] ##1 (!debugWireOe_n && debugWireOut))
        else $error("zero bit shape wrong");
    host_starts_a: assert property (
        $fell(debugWireOe_n) |-> quiet_ff < 10'd16) else $error("drive without host edge");
    timeout_span_a: assert property (
        cmdAbort |-> quiet_ff >= 10'd511 && quiet_ff <= 10'd520) else $error("abort timing");
    bg_needed_a: assert property (
        cpuResume || cpuStep |-> $past(activeBackground)) else $error("cpu command in user");
    cover property ($fell(debugWireOe_n) && !debugWireOut);
    cover property (cmdAbort);
    cover property (cpuWake);
endmodule

// file: tb/swdbg_tb.sv
// top bench for the debug bit port
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb
    import swdbg_pkg::*;
();
    logic clk, sys_rst, porFlag, forceBgReq, cpuStopped;
    logic [15:0] cpuAddr, bkptAddr;
    logic padLevel, debugWireOut, debugWireOe_n, activeBackground, debugClockSelect;
    logic cpuResume, cpuStep, cpuWake, oscKeepRun, watchdogHold, bkptHit, cmdAbort;
    logic [7:0] rd; // status byte read back
    int errors = 0, num_checks = 0, resumeCnt = 0, stepCnt = 0, wakeCnt = 0, abortCnt = 0;
    swdbg_port u_dut (.clk(clk), .sys_rst(sys_rst), .porFlag(porFlag),
        .forceBgReq(forceBgReq), .cpuStopped(cpuStopped), .cpuAddr(cpuAddr),
        .bkptAddr(bkptAddr), .debugWireIn(padLevel), .debugWireOut(debugWireOut),
        .debugWireOe_n(debugWireOe_n), .activeBackground(activeBackground),
        .debugClockSelect(debugClockSelect), .cpuResume(cpuResume), .cpuStep(cpuStep),
        .cpuWake(cpuWake), .oscKeepRun(oscKeepRun), .watchdogHold(watchdogHold),
        .bkptHit(bkptHit), .cmdAbort(cmdAbort));
    swdbg_host u_host (.clk(clk), .debugWireOut(debugWireOut),
        .debugWireOe_n(debugWireOe_n), .padLevel(padLevel));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // count one-cycle pulses
    always @(posedge clk)
    begin
        resumeCnt += (cpuResume === 1'b1);
        stepCnt += (cpuStep === 1'b1);
        wakeCnt += (cpuWake === 1'b1);
        abortCnt += (cmdAbort === 1'b1);
    end
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // reset with chosen cause and wire level
    task automatic rst_dut(input logic por, input logic low);
        porFlag <= por;
        u_host.hostDrv <= low;
        u_host.hostLvl <= 1'b0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        u_host.hostDrv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset;
        rst_dut(1'b1, 1'b1);
        `CHK(activeBackground, 1'b1)
        `CHK(watchdogHold, 1'b1)
        rst_dut(1'b0, 1'b1);
        `CHK(activeBackground, 1'b0)
        rst_dut(1'b1, 1'b0);
        `CHK(activeBackground, 1'b0)
        $display("reset test done");
    endtask
    task automatic t_user;
        u_host.send_byte(CMD_GO);
        repeat (30) @(posedge clk);
        `CHK(resumeCnt, 0)
        u_host.send_byte(CMD_WRCTRL);
        u_host.send_byte(8'h8a);
        repeat (4) @(posedge clk);
        `CHK(debugClockSelect, 1'b1)
        `CHK(oscKeepRun, 1'b1)
        u_host.send_byte(CMD_RDSTAT);
        u_host.recv_byte(rd);
        `CHK(rd, 8'h8a)
        $display("user test done");
    endtask
    task automatic t_wake;
        cpuStopped <= 1'b1;
        u_host.send_byte(CMD_BACKGROUND);
        repeat (30) @(posedge clk);
        `CHK(wakeCnt, 1)
        `CHK(activeBackground, 1'b1)
        cpuStopped <= 1'b0;
        u_host.send_byte(CMD_STEP);
        repeat (30) @(posedge clk);
        `CHK(stepCnt, 1)
        u_host.send_byte(CMD_GO);
        repeat (30) @(posedge clk);
        `CHK(resumeCnt, 1)
        $display("wake test done");
    endtask
    task automatic t_force_abort;
        rst_dut(1'b0, 1'b0);
        forceBgReq <= 1'b1;
        @(posedge clk);
        forceBgReq <= 1'b0;
        u_host.send_byte(CMD_RDSTAT);
        u_host.recv_byte(rd);
        `CHK(activeBackground, 1'b1)
        `CHK(rd, 8'h01)
        u_host.send_bit(1'b1);
        u_host.send_bit(1'b1);
        u_host.send_bit(1'b0);
        repeat (600) @(posedge clk);
        `CHK(abortCnt, 1)
        u_host.send_byte(CMD_RDSTAT);
        u_host.recv_byte(rd);
        `CHK(rd, 8'h01)
        $display("force and abort test done");
    endtask
    task automatic t_bkpt;
        cpuAddr <= 16'h1234;
        bkptAddr <= 16'h1234;
        repeat (3) @(posedge clk);
        `CHK(bkptHit, 1'b0)
        u_host.send_byte(CMD_WRCTRL);
        u_host.send_byte(8'h80);
        repeat (3) @(posedge clk);
        `CHK(bkptHit, 1'b1)
        bkptAddr <= 16'h1235;
        repeat (3) @(posedge clk);
        `CHK(bkptHit, 1'b0)
        $display("breakpoint test done");
    endtask
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        porFlag = 1'b0;
        forceBgReq = 1'b0;
        cpuStopped = 1'b0;
        cpuAddr = 16'h0000;
        bkptAddr = 16'h0001;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_user();
        t_wake();
        t_force_abort();
        t_bkpt();
        final_report();
    end
    // hang guard, run needs about 3500 cycles
    initial
    begin
        #200000;
        errors++;
        final_report();
    end
endmodule
bind swdbg_port swdbg_port_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .sys_rst(sys_rst),
    .porFlag(porFlag), .cpuAddr(cpuAddr), .bkptAddr(bkptAddr), .debugWireIn(debugWireIn),
    .debugWireOut(debugWireOut), .debugWireOe_n(debugWireOe_n),
    .activeBackground(activeBackground), .oscKeepRun(oscKeepRun), .watchdogHold(watchdogHold),
    .cpuResume(cpuResume), .cpuStep(cpuStep), .cpuWake(cpuWake), .bkptHit(bkptHit),
    .cmdAbort(cmdAbort));
